// ===== core/dspt_pkg.sv
// constants, register map and types of the dual-slope pulse-width timer
package dspt_pkg;

  // ==========================================================
  // register byte offsets on the apb bus
  localparam logic [11:0] OFS_CTRL_A = 12'h080;
  localparam logic [11:0] OFS_CTRL_B = 12'h084;
  localparam logic [11:0] OFS_CMP_A = 12'h088;
  localparam logic [11:0] OFS_CMP_B = 12'h08c;
  localparam logic [11:0] OFS_CAP_TOP = 12'h090;
  localparam logic [11:0] OFS_COUNT = 12'h094;
  localparam logic [11:0] OFS_FLAGS = 12'h098;
  localparam logic [11:0] OFS_PIN_DIR = 12'h09c;

  // ==========================================================
  // field positions and reset values
  localparam int ACT_A_LSB = 6;
  localparam int ACT_B_LSB = 4;
  localparam int MODE_LO_LSB = 0;
  localparam logic [7:0] CTRL_A_WMASK = 8'hf3;
  localparam logic [7:0] RST_CTRL_A = 8'h00;
  localparam logic [1:0] RST_MODE_HI = 2'h0;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [15:0] RST_CMP = 16'h0000;
  localparam logic [15:0] RST_CAP_TOP = 16'h0000;
  localparam logic [3:0] RST_FLAGS = 4'h0;
  localparam logic [1:0] RST_PIN_DIR = 2'h0;
  localparam int FLAG_OVF = 0;
  localparam int FLAG_MATCH_A = 1;
  localparam int FLAG_MATCH_B = 2;
  localparam int FLAG_CAPTURE = 3;

  // ==========================================================
  // counter limits
  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  localparam logic [15:0] COUNT_STEP = 16'h0001;

  // ==========================================================
  // waveform modes and output actions
  localparam logic [3:0] MODE_PC_8 = 4'h1;
  localparam logic [3:0] MODE_PC_9 = 4'h2;
  localparam logic [3:0] MODE_PC_10 = 4'h3;
  localparam logic [3:0] MODE_PFC_CAP = 4'h8;
  localparam logic [3:0] MODE_PFC_CMPA = 4'h9;
  localparam logic [3:0] MODE_PC_CAP = 4'ha;
  localparam logic [3:0] MODE_PC_CMPA = 4'hb;
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_NONINV = 2'h2;
  localparam logic [1:0] ACT_INV = 2'h3;

  typedef enum logic {
    DIR_UP = 1'b0,
    DIR_DOWN = 1'b1
  } dspt_dir_t;

endpackage : dspt_pkg

// ===== core/dspt_chan.sv
// one compare channel: buffered compare value, match and waveform register
`timescale 1ns/10ps
module dspt_chan (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  input wire logic load_now,
  input wire logic match_en,
  input wire logic up_event,
  input wire logic [1:0] action,
  input wire logic toggle_ok,
  input wire logic [15:0] count,
  output logic [15:0] active,
  output logic [15:0] buffered,
  output logic match,
  output logic wave
);
  import dspt_pkg::*;

  typedef struct packed {
    logic [15:0] buffer_val;
    logic [15:0] active_val;
    logic wave;
  } dspt_chan_t;

  dspt_chan_t st_q;
  dspt_chan_t st_d;

  assign match = match_en && (count == st_q.active_val);
  assign active = st_q.active_val;
  assign buffered = st_q.buffer_val;
  assign wave = st_q.wave;

  // ==========================================================
  // next state
  always_comb
  begin
    st_d = st_q;
    if (load_now)
    begin
      st_d.active_val = st_q.buffer_val;
    end
    if (wr_en)
    begin
      st_d.buffer_val = wr_data;
    end
    if (match)
    begin
      case (action)
        ACT_TOGGLE: st_d.wave = toggle_ok ? ~st_q.wave : st_q.wave;
        ACT_NONINV: st_d.wave = ~up_event;
        ACT_INV: st_d.wave = up_event;
        default: st_d.wave = st_q.wave;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      st_q <= '{buffer_val: RST_CMP, active_val: RST_CMP, wave: 1'b0};
    end
    else if (clk_en)
    begin
      st_q <= st_d;
    end
  end

endmodule : dspt_chan

// ===== core/dspt_top.sv
// dual-slope pulse-width timer: counter, flags, apb registers and pin drive
// Functional notes
// - phase-correct loads compare buffers at top
// - action two non-inverted, three inverted
// - waveform drives pin only when direction bit set
// - match sets/clears output by slope direction
// - period is twice prescale times top
// - non-inverted: compare bottom holds low, top holds high
// - mode 11 toggle action gives half duty
// - mode 9 toggle action gives half duty
// - modes 8 and 9 count up, down
// - top from capture or compare a, held one tick
// - frequency-correct loads buffers and overflow at bottom
// - top-defining register flag set at top
// - match flag when count equals compare value
// - counter advances only on timer tick enable
// - control a layout, bits 3:2 read zero
// - mode joins control a and control b bits
// - toggle action only modes 8 to 11, channel a
// - phase-correct overflow at bottom, top flags at top
// - fixed tops for modes 1, 2 and 3
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
module dspt_top (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic timer_tick,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic wave_pin_a_out,
  output logic wave_pin_a_oe,
  output logic wave_pin_b_out,
  output logic wave_pin_b_oe
);
  import dspt_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [1:0] mode_hi;
    logic [15:0] cap_top;
    logic [15:0] count;
    dspt_dir_t dir;
    logic [3:0] flags;
    logic [1:0] pin_dir;
    logic [31:0] rdata;
    logic slverr;
    logic armed;
  } dspt_state_t;

  dspt_state_t st_q;
  dspt_state_t st_d;

  logic [3:0] wave_mode_sel;
  logic [1:0] action_a, action_b;
  logic dual;
  logic freq_correct;
  logic top_is_cap, top_is_cmp_a;
  logic [15:0] top_val;
  logic at_top, at_bottom;
  logic up_event;
  logic count_go;
  logic load_now;
  logic toggle_ok_a;
  logic conn_a, conn_b;
  logic acc_wr;
  logic capture;
  logic addr_ok;
  logic [31:0] rd_mux;
  logic [15:0] active_a, active_b;
  logic [15:0] buffered_a, buffered_b;
  logic match_a, match_b;
  logic wave_a, wave_b;
  logic [3:0] flag_set, flag_clr;

  // ==========================================================
  // mode decode
  assign wave_mode_sel = {st_q.mode_hi, st_q.ctrl_a[MODE_LO_LSB +: 2]};
  assign action_a = st_q.ctrl_a[ACT_A_LSB +: 2];
  assign action_b = st_q.ctrl_a[ACT_B_LSB +: 2];

  always_comb
  begin
    dual = 1'b1;
    freq_correct = 1'b0;
    top_is_cap = 1'b0;
    top_is_cmp_a = 1'b0;
    top_val = TOP_8BIT;
    case (wave_mode_sel)
      MODE_PC_8: top_val = TOP_8BIT;
      MODE_PC_9: top_val = TOP_9BIT;
      MODE_PC_10: top_val = TOP_10BIT;
      MODE_PFC_CAP:
      begin
        freq_correct = 1'b1;
        top_is_cap = 1'b1;
        top_val = st_q.cap_top;
      end
      MODE_PFC_CMPA:
      begin
        freq_correct = 1'b1;
        top_is_cmp_a = 1'b1;
        top_val = active_a;
      end
      MODE_PC_CAP:
      begin
        top_is_cap = 1'b1;
        top_val = st_q.cap_top;
      end
      MODE_PC_CMPA:
      begin
        top_is_cmp_a = 1'b1;
        top_val = active_a;
      end
      default: dual = 1'b0;
    endcase
  end

  assign at_top = dual && (st_q.count == top_val);
  assign at_bottom = dual && (st_q.count == BOTTOM);
  // the turning points belong to the slope that follows them
  assign up_event = at_bottom ? 1'b1 : (at_top ? 1'b0 : (st_q.dir == DIR_UP));
  assign count_go = timer_tick && dual;
  // buffered compare update point depends on the correction flavour
  assign load_now = !dual ? 1'b1 :
                    (freq_correct ? (count_go && at_bottom) : (count_go && at_top));
  assign toggle_ok_a = wave_mode_sel[3] && !wave_mode_sel[2];
  assign conn_a = dual && (action_a != ACT_OFF) && ((action_a != ACT_TOGGLE) || toggle_ok_a);
  assign conn_b = dual && (action_b != ACT_OFF) && (action_b != ACT_TOGGLE);

  // ==========================================================
  // apb slave
  // read data latched on an enabled edge before the access may complete
  assign capture = psel && !st_q.armed;
  assign acc_wr = pready && pwrite;
  assign pready = psel && penable && clk_en && st_q.armed;
  assign prdata = st_q.rdata;
  assign pslverr = st_q.slverr;

  always_comb
  begin
    addr_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFS_CTRL_A: rd_mux = {24'h00_0000, st_q.ctrl_a};
      OFS_CTRL_B: rd_mux = {30'h0000_0000, st_q.mode_hi};
      OFS_CMP_A: rd_mux = {16'h0000, buffered_a};
      OFS_CMP_B: rd_mux = {16'h0000, buffered_b};
      OFS_CAP_TOP: rd_mux = {16'h0000, st_q.cap_top};
      OFS_COUNT: rd_mux = {16'h0000, st_q.count};
      OFS_FLAGS: rd_mux = {28'h000_0000, st_q.flags};
      OFS_PIN_DIR: rd_mux = {30'h0000_0000, st_q.pin_dir};
      default: addr_ok = 1'b0;
    endcase
  end

  // ==========================================================
  // compare channels
  dspt_chan u_chan_a (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .clk_en(clk_en),
    .wr_en(acc_wr && (paddr == OFS_CMP_A)),
    .wr_data(pwdata[15:0]),
    .load_now(load_now),
    .match_en(count_go),
    .up_event(up_event),
    .action(action_a),
    .toggle_ok(toggle_ok_a),
    .count(st_q.count),
    .active(active_a),
    .buffered(buffered_a),
    .match(match_a),
    .wave(wave_a)
  );

  dspt_chan u_chan_b (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .clk_en(clk_en),
    .wr_en(acc_wr && (paddr == OFS_CMP_B)),
    .wr_data(pwdata[15:0]),
    .load_now(load_now),
    .match_en(count_go),
    .up_event(up_event),
    .action(action_b),
    .toggle_ok(1'b0),
    .count(st_q.count),
    .active(active_b),
    .buffered(buffered_b),
    .match(match_b),
    .wave(wave_b)
  );

  // ==========================================================
  // pin drive
  assign wave_pin_a_out = wave_a;
  assign wave_pin_b_out = wave_b;
  assign wave_pin_a_oe = conn_a && st_q.pin_dir[0];
  assign wave_pin_b_oe = conn_b && st_q.pin_dir[1];

  // ==========================================================
  // flags
  always_comb
  begin
    flag_set = 4'h0;
    flag_set[FLAG_OVF] = count_go && at_bottom;
    flag_set[FLAG_MATCH_A] = match_a || (count_go && at_top && top_is_cmp_a);
    flag_set[FLAG_MATCH_B] = match_b;
    flag_set[FLAG_CAPTURE] = count_go && at_top && top_is_cap;
    flag_clr = (acc_wr && (paddr == OFS_FLAGS)) ? pwdata[3:0] : 4'h0;
  end

  // ==========================================================
  // next state
  always_comb
  begin
    st_d = st_q;
    // a flag raised while being cleared survives
    st_d.flags = (st_q.flags & ~flag_clr) | flag_set;
    if (count_go)
    begin
      if (st_q.dir == DIR_UP)
      begin
        if (at_top)
        begin
          st_d.dir = DIR_DOWN;
          st_d.count = top_val - COUNT_STEP;
        end
        else
        begin
          st_d.count = st_q.count + COUNT_STEP;
        end
      end
      else
      begin
        if (at_bottom)
        begin
          st_d.dir = DIR_UP;
          st_d.count = BOTTOM + COUNT_STEP;
        end
        else
        begin
          st_d.count = st_q.count - COUNT_STEP;
        end
      end
    end
    else if (!dual)
    begin
      st_d.dir = DIR_UP;
      st_d.count = RST_COUNT;
    end
    st_d.armed = psel && !pready;
    if (capture)
    begin
      st_d.rdata = pwrite ? 32'h0000_0000 : rd_mux;
      st_d.slverr = !addr_ok;
    end
    if (acc_wr)
    begin
      case (paddr)
        OFS_CTRL_A: st_d.ctrl_a = pwdata[7:0] & CTRL_A_WMASK;
        OFS_CTRL_B: st_d.mode_hi = pwdata[1:0];
        OFS_CAP_TOP: st_d.cap_top = pwdata[15:0];
        OFS_PIN_DIR: st_d.pin_dir = pwdata[1:0];
        default: st_d.slverr = st_q.slverr;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      st_q <= '{ctrl_a: RST_CTRL_A, mode_hi: RST_MODE_HI, cap_top: RST_CAP_TOP,
                count: RST_COUNT, dir: DIR_UP, flags: RST_FLAGS,
                pin_dir: RST_PIN_DIR, rdata: 32'h0000_0000, slverr: 1'b0, armed: 1'b0};
    end
    else if (clk_en)
    begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  sequence s_turn_top;
    clk_en && count_go && (st_q.dir == DIR_UP) && at_top;
  endsequence

  sequence s_turn_bottom;
    clk_en && count_go && (st_q.dir == DIR_DOWN) && at_bottom;
  endsequence

  property p_top_turn;
    s_turn_top |=> (st_q.dir == DIR_DOWN) && (st_q.count == $past(top_val) - COUNT_STEP);
  endproperty
  a_top_turn:
    assert property (p_top_turn) else $error("no reversal at top");
  property p_bottom_turn;
    s_turn_bottom |=> (st_q.dir == DIR_UP) && (st_q.count == COUNT_STEP);
  endproperty
  a_bottom_turn:
    assert property (p_bottom_turn) else $error("no reversal at bottom");
  property p_overflow;
    (clk_en && count_go && at_bottom) |=> st_q.flags[FLAG_OVF];
  endproperty
  a_overflow:
    assert property (p_overflow) else $error("overflow flag missed at bottom");
  property p_pfc_load;
    (clk_en && freq_correct && count_go && at_bottom) |=> (active_a == $past(buffered_a));
  endproperty
  a_pfc_load:
    assert property (p_pfc_load) else $error("compare not loaded at bottom");
  property p_pc_hold;
    (clk_en && dual && !freq_correct && !(count_go && at_top)) |=> $stable(active_b);
  endproperty
  a_pc_hold:
    assert property (p_pc_hold) else $error("compare changed away from top");
  property p_no_tick;
    (clk_en && dual && !timer_tick) |=> $stable(st_q.count);
  endproperty
  a_no_tick:
    assert property (p_no_tick) else $error("counter moved without tick");
  property p_pin_gate;
    wave_pin_a_oe |-> (st_q.pin_dir[0] && dual && (action_a != ACT_OFF));
  endproperty
  a_pin_gate:
    assert property (p_pin_gate) else $error("pin a driven without direction");
  property p_ro_bits;
    st_q.ctrl_a[3:2] == 2'h0;
  endproperty
  a_ro_bits:
    assert property (p_ro_bits) else $error("read-only control bits set");
  property p_noninv_up;
    (clk_en && match_b && up_event && action_b == ACT_NONINV) |=> !wave_b;
  endproperty
  a_noninv_up:
    assert property (p_noninv_up) else $error("non-inverted output not cleared");
  property p_toggle_a;
    (clk_en && match_a && action_a == ACT_TOGGLE && toggle_ok_a) |=> (wave_a != $past(wave_a));
  endproperty
  a_toggle_a:
    assert property (p_toggle_a) else $error("output a did not toggle");
  property p_cap_flag;
    (s_turn_top ##0 top_is_cap) |=> st_q.flags[FLAG_CAPTURE];
  endproperty
  a_cap_flag:
    assert property (p_cap_flag) else $error("capture flag missed at top");

endmodule : dspt_top

// ===== tb/dspt_pin_load.sv
// pin load model: resolves the pin level seen by the external load
`timescale 1ns/10ps
module dspt_pin_load (
  input wire logic drv_out,
  input wire logic drv_oe,
  output logic level
);
  // released pin sinks to the pull-down
  assign level = drv_oe ? drv_out : 1'b0;
endmodule : dspt_pin_load

// ===== tb/tb_dual_slope_pwm_timer16.sv
// self-checking bench of the dual-slope pulse-width timer
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin mismatches++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module tb_dual_slope_pwm_timer16;
  import dspt_pkg::*;
  logic clk_sys = 0, nrst = 0, clk_en = 1, timer_tick = 0, run = 0;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, wa_out, wa_oe, wb_out, wb_oe, lvl_a, lvl_b;
  logic [7:0] lfsr = 8'h5f;
  int checks = 0, mismatches = 0, cyc = 0;
  logic [32:0] rq[$];
  logic [32:0] exp_q;
  // ==========================================================
  // shadow registers and reference model
  logic [1:0] s_aa, s_ab, s_mlo, s_mhi, s_dir;
  logic [15:0] s_ca, s_cb, s_cap, m_cnt, m_act_a, m_act_b, m_top;
  logic m_dn, m_wa, m_wb;
  logic [3:0] m_fl;
  wire [3:0] s_mode = {s_mhi, s_mlo};
  wire m_pfc = s_mode == MODE_PFC_CAP || s_mode == MODE_PFC_CMPA;
  wire m_dual = m_pfc || (s_mode >= MODE_PC_8 && s_mode <= MODE_PC_10) ||
    s_mode == MODE_PC_CAP || s_mode == MODE_PC_CMPA;
  wire m_up = m_cnt == BOTTOM || (!m_dn && m_cnt != m_top);
  wire m_at_top = m_cnt == m_top && !m_dn;
  wire m_oe_a = m_dual && s_dir[0] && (s_aa[1] || (s_aa == ACT_TOGGLE && s_mode >= 4'h8));
  wire m_oe_b = m_dual && s_dir[1] && s_ab[1];

  function automatic logic [7:0] lfsr_next(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr_next

  always_comb
    case (s_mode)
      MODE_PC_8: m_top = TOP_8BIT;
      MODE_PC_9: m_top = TOP_9BIT;
      MODE_PC_10: m_top = TOP_10BIT;
      MODE_PFC_CAP, MODE_PC_CAP: m_top = s_cap;
      default: m_top = m_act_a;
    endcase

  always @(posedge clk_sys)
    if (!nrst)
    begin
      m_cnt <= RST_COUNT;
      m_dn <= DIR_UP;
      m_wa <= 1'b0;
      m_wb <= 1'b0;
      m_fl <= RST_FLAGS;
      m_act_a <= RST_CMP;
      m_act_b <= RST_CMP;
    end
    else if (clk_en && !m_dual)
    begin
      m_act_a <= s_ca;
      m_act_b <= s_cb;
    end
    else if (clk_en && timer_tick)
    begin
      m_cnt <= m_up ? m_cnt + COUNT_STEP : m_cnt - COUNT_STEP;
      m_dn <= !m_up;
      if (m_cnt == BOTTOM)
        m_fl[FLAG_OVF] <= 1'b1;
      if (m_at_top && (s_mode == MODE_PFC_CAP || s_mode == MODE_PC_CAP))
        m_fl[FLAG_CAPTURE] <= 1'b1;
      if (m_pfc ? m_cnt == BOTTOM : m_at_top)
      begin
        m_act_a <= s_ca;
        m_act_b <= s_cb;
      end
      if (m_cnt == m_act_a)
      begin
        m_fl[FLAG_MATCH_A] <= 1'b1;
        if (s_aa == ACT_TOGGLE && s_mode >= 4'h8)
          m_wa <= !m_wa;
        else if (s_aa[1])
          m_wa <= s_aa[0] ^ !m_up;
      end
      if (m_cnt == m_act_b)
      begin
        m_fl[FLAG_MATCH_B] <= 1'b1;
        if (s_ab[1])
          m_wb <= s_ab[0] ^ !m_up;
      end
    end

  // ==========================================================
  // design, far-side load, clock, ticks and monitors
  dspt_top i_dut (
    .clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en), .timer_tick(timer_tick),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .wave_pin_a_out(wa_out), .wave_pin_a_oe(wa_oe),
    .wave_pin_b_out(wb_out), .wave_pin_b_oe(wb_oe)
  );
  dspt_pin_load i_load_a (.drv_out(wa_out), .drv_oe(wa_oe), .level(lvl_a));
  dspt_pin_load i_load_b (.drv_out(wb_out), .drv_oe(wb_oe), .level(lvl_b));

  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    lfsr <= lfsr_next(lfsr);
    timer_tick <= run && lfsr[1:0] != 2'h0;
    clk_en <= !(run && lfsr[6:3] == 4'hf);
    cyc <= cyc + 1;
    if (cyc == 15000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  always @(posedge clk_sys)
    if (psel && penable && pready && !pwrite && rq.size() > 0)
    begin
      exp_q = rq.pop_front();
      `CHK("read", exp_q, {pslverr, prdata})
    end

  always @(negedge clk_sys)
    if (nrst)
    begin
      `CHK("oe_a", m_oe_a, wa_oe)
      `CHK("oe_b", m_oe_b, wb_oe)
      `CHK("wave_a", m_wa, wa_out)
      `CHK("wave_b", m_wb, wb_out)
      `CHK("pin_a", m_oe_a & m_wa, lvl_a)
      `CHK("pin_b", m_oe_b & m_wb, lvl_b)
    end

  // ==========================================================
  // bus tasks and scenarios
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    input logic [32:0] ex);
    if (!wr)
      rq.push_back(ex);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
    begin
      @(posedge clk_sys);
    end
    if (wr)
      case (a)
        OFS_CTRL_A: {s_aa, s_ab, s_mlo} <= {d[7:4], d[1:0]};
        OFS_CTRL_B: s_mhi <= d[1:0];
        OFS_CMP_A: s_ca <= d[15:0];
        OFS_CMP_B: s_cb <= d[15:0];
        OFS_CAP_TOP: s_cap <= d[15:0];
        OFS_PIN_DIR: s_dir <= d[1:0];
        default: ;
      endcase
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic do_reset();
    nrst <= 1'b0;
    {s_aa, s_ab, s_mlo, s_mhi, s_dir} <= '0;
    {s_ca, s_cb, s_cap} <= '0;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
  endtask : do_reset

  task automatic run_cfg(input logic [3:0] md, input logic [1:0] aa, input logic [1:0] ab,
    input logic [15:0] ca, input logic [15:0] cb, input logic [15:0] cap,
    input logic [15:0] cb2);
    do_reset();
    apb(1'b1, OFS_CMP_A, {16'h0, ca}, 33'h0);
    apb(1'b1, OFS_CMP_B, {16'h0, cb}, 33'h0);
    apb(1'b1, OFS_CAP_TOP, {16'h0, cap}, 33'h0);
    apb(1'b1, OFS_PIN_DIR, 32'h3, 33'h0);
    apb(1'b1, OFS_CTRL_B, {30'h0, md[3:2]}, 33'h0);
    apb(1'b1, OFS_CTRL_A, {24'h0, aa, ab, 2'h0, md[1:0]}, 33'h0);
    run <= 1'b1;
    repeat (300) @(posedge clk_sys);
    apb(1'b1, OFS_CMP_B, {16'h0, cb2}, 33'h0);
    repeat (300) @(posedge clk_sys);
    run <= 1'b0;
    repeat (3) @(posedge clk_sys);
    apb(1'b0, OFS_COUNT, 32'h0, {17'h0, m_cnt});
    if (m_dual)
    begin
      apb(1'b0, OFS_FLAGS, 32'h0, {29'h0, m_fl});
      apb(1'b1, OFS_FLAGS, 32'hf, 33'h0);
      apb(1'b0, OFS_FLAGS, 32'h0, 33'h0);
    end
  endtask : run_cfg

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  initial
  begin
    do_reset();
    apb(1'b0, OFS_CTRL_A, 32'h0, 33'h0);
    apb(1'b0, OFS_COUNT, 32'h0, 33'h0);
    apb(1'b1, OFS_CTRL_A, 32'hffffffff, 33'h0);
    apb(1'b0, OFS_CTRL_A, 32'h0, 33'h0f3);
    apb(1'b1, OFS_COUNT, 32'h1234, 33'h0);
    apb(1'b0, OFS_COUNT, 32'h0, 33'h0);
    apb(1'b0, 12'h0a0, 32'h0, {1'b1, 32'h0});
    run_cfg(MODE_PFC_CMPA, ACT_TOGGLE, ACT_NONINV, 16'h5, 16'h2, 16'h0, 16'h4);
    run_cfg(MODE_PFC_CAP, ACT_INV, ACT_NONINV, 16'h0, 16'h6, 16'h6, 16'h6);
    run_cfg(MODE_PC_CMPA, ACT_TOGGLE, ACT_TOGGLE, 16'h4, 16'h1, 16'h0, 16'h3);
    run_cfg(MODE_PC_CAP, ACT_NONINV, ACT_INV, 16'h1, 16'h3, 16'h3, 16'h2);
    run_cfg(MODE_PC_8, ACT_INV, ACT_NONINV, 16'h80, 16'hff, 16'h0, 16'h40);
    run_cfg(MODE_PC_9, ACT_NONINV, ACT_INV, 16'h1ff, 16'h10, 16'h0, 16'h20);
    run_cfg(MODE_PC_10, ACT_TOGGLE, ACT_INV, 16'h10, 16'h3ff, 16'h0, 16'h20);
    run_cfg(4'h0, ACT_TOGGLE, ACT_NONINV, 16'h1, 16'h1, 16'h0, 16'h2);
    report_and_stop();
  end
endmodule : tb_dual_slope_pwm_timer16
